/* core/swd_pkg.sv */
// package: register map, fields, reset values and timing of the watchdog
package swd_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [31:0] SWD_OFF_COUNT = 32'h5000_3100;
  localparam logic [31:0] SWD_OFF_CTRL = 32'h5000_3102;
  localparam logic [31:0] SWD_OFF_FREEZE = 32'h5000_3104;
  localparam logic [31:0] SWD_OFF_UNFREEZE = 32'h5000_3106;
  localparam logic [31:0] SWD_OFF_IRQ_STAT = 32'h5000_3108;
  localparam logic [31:0] SWD_OFF_IRQ_MASK = 32'h5000_310A;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int SWD_KEY_LSB = 9;
  localparam int SWD_KEY_MSB = 15;
  localparam int SWD_SIGN_BIT = 8;
  localparam int SWD_MODE_BIT = 0;
  localparam int SWD_FRZ_BIT = 0;
  localparam int SWD_EV_NMI_BIT = 0;
  localparam int SWD_EV_RST_BIT = 1;

  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [8:0] SWD_COUNT_RESET = 9'h0FF;
  localparam logic [8:0] SWD_COUNT_RELOAD = 9'h0FF;
  localparam logic [8:0] SWD_COUNT_ZERO = 9'h000;
  localparam logic [8:0] SWD_COUNT_FIRE = 9'h1F0;
  localparam logic [6:0] SWD_KEY_OPEN = 7'h00;
  localparam logic [1:0] SWD_EV_RESET = 2'h0;
  localparam logic [15:0] SWD_DATA_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // timing: one tick every 10.24 ms on a 25 ns clock
  // ----------------------------------------------------------------
  localparam int SWD_TICK_PERIOD_NS = 10240000;
  localparam int SWD_CLK_PERIOD_NS = 25;
  localparam int SWD_TICK_CYCLES = SWD_TICK_PERIOD_NS / SWD_CLK_PERIOD_NS;

  // register port request carried as one bundle
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } swd_bus_req_s;

endpackage : swd_pkg

/* core/swd_top.sv */
// system watchdog: 9-bit signed down counter, nmi and system reset request
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps

// Function
// - count writes are accepted only when key bits 15:9 are all zero
// - an accepted write loads bits 8:0, sign included, as the new count
// - reading the counter returns the live count, key bits read zero
// - count drops by one on every 10.24 ms tick
// - bit 8 is the sign, one means the count is negative
// - in interrupt-first mode the count wraps below zero to 1FF and keeps falling, nine-bit
// - interrupt-first mode raises an nmi when the count reaches zero
// - interrupt-first mode resets the system at 1F0 and reloads FF
// - reset-only mode resets at zero or below and reloads FF, no nmi
// - mode bit settable by software, cleared only by watchdog or sw reset
// - freeze is accepted only in interrupt-first mode; unfreeze clears the freeze in either mode
// - count is held while the processor is halted in debug
module swd_top import swd_pkg::*; #(
  parameter int TICK_CYCLES = SWD_TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire swd_bus_req_s bus_req,
  output logic [15:0] bus_rdata,
  input wire logic debug_halt,
  input wire logic sw_reset_req,
  output logic nmi_req,
  output logic wdog_rst_req,
  output logic irq
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [TW-1:0] TICK_ZERO = '0;

  // address decode used for every register
  function automatic logic reg_hit(input logic [31:0] a,
                                   input logic [31:0] off);
    reg_hit = (a == off);
  endfunction : reg_hit

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic wr_count;
  logic wr_ctrl;
  logic wr_freeze;
  logic wr_unfreeze;
  logic wr_stat;
  logic wr_mask;
  logic key_ok;

  // write strobes per register
  assign wr_count = bus_req.wr && reg_hit(bus_req.addr, SWD_OFF_COUNT);
  assign wr_ctrl = bus_req.wr && reg_hit(bus_req.addr, SWD_OFF_CTRL);
  assign wr_freeze = bus_req.wr && reg_hit(bus_req.addr, SWD_OFF_FREEZE);
  assign wr_unfreeze = bus_req.wr && reg_hit(bus_req.addr, SWD_OFF_UNFREEZE);
  assign wr_stat = bus_req.wr && reg_hit(bus_req.addr, SWD_OFF_IRQ_STAT);
  assign wr_mask = bus_req.wr && reg_hit(bus_req.addr, SWD_OFF_IRQ_MASK);
  // runaway code rarely writes an all-zero key
  assign key_ok =
    (bus_req.wdata[SWD_KEY_MSB:SWD_KEY_LSB] == SWD_KEY_OPEN);

  // ----------------------------------------------------------------
  // tick timebase
  // ----------------------------------------------------------------
  logic [TW-1:0] tick_cnt_reg;
  logic [TW-1:0] tick_cnt_next;
  logic tick;

  // free-running prescaler; freezing only gates the decrement
  always_comb begin
    tick = (tick_cnt_reg == TICK_LAST);
    tick_cnt_next = tick ? TICK_ZERO : tick_cnt_reg + TW'(1);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // counter, mode and freeze
  // ----------------------------------------------------------------
  logic [8:0] count_reg;
  logic [8:0] count_next;
  logic mode_reg;
  logic mode_next;
  logic frozen_reg;
  logic frozen_next;
  logic was_zero_reg;
  logic was_zero_next;
  logic nmi_reg;
  logic nmi_next;
  logic rst_req_reg;
  logic rst_req_next;
  logic hold;
  logic fire;
  logic negative;

  always_comb begin
    negative = count_reg[SWD_SIGN_BIT];
    // reset-only mode cannot be frozen by software
    hold = debug_halt || (frozen_reg && !mode_reg);
    if (mode_reg) begin
      fire = (count_reg == SWD_COUNT_ZERO) || negative;
    end else begin
      fire = (count_reg == SWD_COUNT_FIRE);
    end
    count_next = count_reg;
    if (fire || sw_reset_req) begin
      count_next = SWD_COUNT_RELOAD;
    end else if (wr_count && key_ok) begin
      count_next = bus_req.wdata[SWD_SIGN_BIT:0];
    end else if (tick && !hold) begin
      // nine-bit wrap: 000 goes to 1FF
      count_next = count_reg - 9'h001;
    end
    // set-only from software, cleared by a system reset
    mode_next = mode_reg;
    if (fire || sw_reset_req) begin
      mode_next = 1'b0;
    end else if (wr_ctrl && bus_req.wdata[SWD_MODE_BIT]) begin
      mode_next = 1'b1;
    end
    frozen_next = frozen_reg;
    if (fire || sw_reset_req) begin
      frozen_next = 1'b0;
    end else if (wr_freeze && bus_req.wdata[SWD_FRZ_BIT] && !mode_reg) begin
      frozen_next = 1'b1;
    end else if (wr_unfreeze && bus_req.wdata[SWD_FRZ_BIT]) begin
      frozen_next = 1'b0;
    end
    // nmi once per arrival at zero, not every cycle spent there
    was_zero_next = (count_reg == SWD_COUNT_ZERO);
    nmi_next = !mode_reg && (count_reg == SWD_COUNT_ZERO)
               && !was_zero_reg;
    rst_req_next = fire;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= SWD_COUNT_RESET;
      mode_reg <= 1'b0;
      frozen_reg <= 1'b0;
      was_zero_reg <= 1'b0;
      nmi_reg <= 1'b0;
      rst_req_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      mode_reg <= mode_next;
      frozen_reg <= frozen_next;
      was_zero_reg <= was_zero_next;
      nmi_reg <= nmi_next;
      rst_req_reg <= rst_req_next;
    end
  end

  assign nmi_req = nmi_reg;
  assign wdog_rst_req = rst_req_reg;

  // ----------------------------------------------------------------
  // event status and mask
  // ----------------------------------------------------------------
  logic [1:0] stat_reg;
  logic [1:0] stat_next;
  logic [1:0] mask_reg;
  logic [1:0] mask_next;
  logic [1:0] ev_set;

  // set beats a write-one clear in the same cycle
  always_comb begin
    ev_set = SWD_EV_RESET;
    ev_set[SWD_EV_NMI_BIT] = nmi_next;
    ev_set[SWD_EV_RST_BIT] = rst_req_next;
    stat_next = stat_reg;
    if (wr_stat) begin
      stat_next = stat_reg & ~bus_req.wdata[1:0];
    end
    stat_next = stat_next | ev_set;
    mask_next = wr_mask ? bus_req.wdata[1:0] : mask_reg;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= SWD_EV_RESET;
      mask_reg <= SWD_EV_RESET;
    end else begin
      stat_reg <= stat_next;
      mask_reg <= mask_next;
    end
  end

  assign irq = |(stat_reg & mask_reg);

  // ----------------------------------------------------------------
  // read port: data stands only in the cycle after the strobe
  // ----------------------------------------------------------------
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  always_comb begin
    rdata_next = SWD_DATA_ZERO;
    if (bus_req.rd) begin
      if (reg_hit(bus_req.addr, SWD_OFF_COUNT)) begin
        rdata_next = {7'h00, count_reg};
      end else if (reg_hit(bus_req.addr, SWD_OFF_CTRL)) begin
        rdata_next = {15'h0000, mode_reg};
      end else if (reg_hit(bus_req.addr, SWD_OFF_FREEZE)) begin
        rdata_next = {15'h0000, frozen_reg};
      end else if (reg_hit(bus_req.addr, SWD_OFF_IRQ_STAT)) begin
        rdata_next = {14'h0000, stat_reg};
      end else if (reg_hit(bus_req.addr, SWD_OFF_IRQ_MASK)) begin
        rdata_next = {14'h0000, mask_reg};
      end else begin
        rdata_next = SWD_DATA_ZERO;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= SWD_DATA_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign bus_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_key_refused: assert property (
    (wr_count && !key_ok && !fire && !sw_reset_req && !(tick && !hold))
    |=> (count_reg == $past(count_reg)))
    else $error("count changed on a write with a nonzero key");

  a_key_load: assert property (
    (wr_count && key_ok && !fire && !sw_reset_req)
    |=> (count_reg == $past(bus_req.wdata[8:0])))
    else $error("accepted write did not load the count");

  a_read_live: assert property (
    (bus_req.rd && reg_hit(bus_req.addr, SWD_OFF_COUNT))
    |=> (bus_rdata == {7'h00, $past(count_reg)}))
    else $error("counter read did not return the live count");

  a_tick_dec: assert property (
    (tick && !hold && !fire && !sw_reset_req && !wr_count)
    |=> (count_reg == $past(count_reg) - 9'h001))
    else $error("tick did not lower the count by one");

  a_zero_wrap: assert property (
    (count_reg == SWD_COUNT_ZERO && !mode_reg && tick && !hold
     && !wr_count && !sw_reset_req)
    |=> (count_reg == 9'h1FF))
    else $error("count did not wrap from zero to 1FF");

  a_nmi_zero: assert property (
    $rose(nmi_req) |-> ($past(count_reg) == SWD_COUNT_ZERO
                        && !$past(mode_reg)))
    else $error("nmi raised away from zero or in reset-only mode");

  a_fire_ifirst: assert property (
    (!mode_reg && count_reg == SWD_COUNT_FIRE)
    |=> (wdog_rst_req && count_reg == SWD_COUNT_RELOAD) ##1 !wdog_rst_req)
    else $error("no single-cycle reset and reload at 1F0");

  a_fire_ronly: assert property (
    (mode_reg && (count_reg == SWD_COUNT_ZERO || negative))
    |=> (wdog_rst_req && !nmi_req && count_reg == SWD_COUNT_RELOAD))
    else $error("reset-only mode missed reset at zero or below");

  a_mode_sticky: assert property (
    (mode_reg && !fire && !sw_reset_req) |=> mode_reg)
    else $error("mode bit cleared by something other than a reset");

  a_debug_hold: assert property (
    (debug_halt && !wr_count && !fire && !sw_reset_req)
    |=> $stable(count_reg))
    else $error("count moved while the processor was halted");

  a_freeze_hold: assert property (
    (frozen_reg && !mode_reg && !wr_count && !fire && !sw_reset_req)
    |=> $stable(count_reg))
    else $error("count moved while frozen in interrupt-first mode");

  a_freeze_block: assert property (
    (wr_freeze && mode_reg && !frozen_reg) |=> !frozen_reg)
    else $error("freeze accepted in reset-only mode");

  a_sw_reset: assert property (
    sw_reset_req |=> (count_reg == SWD_COUNT_RELOAD && !mode_reg))
    else $error("system reset did not restore count and mode");

  c_nmi_seen: cover property (nmi_req);
  c_fire_ifirst: cover property (!mode_reg ##1 wdog_rst_req);
  c_fire_ronly: cover property (mode_reg ##1 wdog_rst_req);
  c_key_refused: cover property (wr_count && !key_ok);
  c_irq_seen: cover property ($rose(irq));

endmodule : swd_top

/* test/swd_sys_model.sv */
// system side model: counts nmi and watchdog reset requests
`timescale 1ns/1ps
module swd_sys_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic nmi_req,
  input wire logic wdog_rst_req,
  output logic [7:0] nmi_seen,
  output logic [7:0] rst_seen,
  output logic [7:0] long_seen
);
  logic rst_d;
  // one count per cycle a request is high; a reset request held two cycles is logged as too long
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_seen <= 8'h00;
      rst_seen <= 8'h00;
      long_seen <= 8'h00;
      rst_d <= 1'b0;
    end else begin
      rst_d <= wdog_rst_req;
      if (nmi_req) nmi_seen <= nmi_seen + 8'h01;
      if (wdog_rst_req) rst_seen <= rst_seen + 8'h01;
      if (wdog_rst_req && rst_d) long_seen <= long_seen + 8'h01;
    end
  end
endmodule : swd_sys_model

/* test/test_system_watchdog_timer.sv */
// testbench for the system watchdog
`timescale 1ns/1ps
module test_system_watchdog_timer import swd_pkg::*;;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic debug_halt = 1'b1;
  logic sw_reset_req = 1'b0;
  swd_bus_req_s req = '0;
  logic [15:0] bus_rdata;
  logic nmi_req, wdog_rst_req, irq;
  logic [7:0] nmi_seen, rst_seen, long_seen;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  // short tick so a test spans a few ticks
  swd_top #(.TICK_CYCLES(8)) uut (.core_clk(core_clk), .rst_n(rst_n),
    .bus_req(req), .bus_rdata(bus_rdata), .debug_halt(debug_halt),
    .sw_reset_req(sw_reset_req), .nmi_req(nmi_req),
    .wdog_rst_req(wdog_rst_req), .irq(irq));
  swd_sys_model model (.core_clk(core_clk), .rst_n(rst_n),
    .nmi_req(nmi_req), .wdog_rst_req(wdog_rst_req), .nmi_seen(nmi_seen),
    .rst_seen(rst_seen), .long_seen(long_seen));

  initial begin
    forever begin
      #12.5 core_clk = ~core_clk;
    end
  end

  // hang guard, well above the few hundred cycles needed
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // ------------------------------------------------
  // bus and compare helpers
  // ------------------------------------------------
  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge core_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask : wr

  // read data stand one cycle only, so take them mid-cycle
  task rchk(input logic [31:0] a, input logic [15:0] e, input string m);
    @(posedge core_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge core_clk);
    req.rd <= 1'b0;
    @(negedge core_clk);
    chk(bus_rdata, e, m);
  endtask : rchk

  // exactly eight edges unhalted: exactly one tick lands
  task run8;
    @(posedge core_clk);
    debug_halt <= 1'b0;
    repeat (8) @(posedge core_clk);
    debug_halt <= 1'b1;
  endtask : run8

  // run until the model sees a pulse, then halt well before the next tick
  task wait_ev(input logic on_rst);
    logic [7:0] n0;
    int i;
    n0 = on_rst ? rst_seen : nmi_seen;
    @(posedge core_clk);
    debug_halt <= 1'b0;
    for (i = 0; i < 40; i++) begin
      @(negedge core_clk);
      if ((on_rst ? rst_seen : nmi_seen) !== n0) break;
    end
    @(posedge core_clk);
    debug_halt <= 1'b1;
    chk({15'h0000, i < 40}, 16'h0001, "event late");
  endtask : wait_ev

  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task t_reset;
    rchk(SWD_OFF_COUNT, 16'h00FF, "count rst");
    rchk(SWD_OFF_CTRL, 16'h0000, "mode rst");
    rchk(32'h5000_310C, 16'h0000, "unmapped");
    $display("test done: reset");
  endtask : t_reset

  task t_key;
    logic [15:0] bad [3];
    bad = '{16'h0212, 16'h8012, 16'hFE12};
    wr(SWD_OFF_COUNT, 16'h0050);
    rchk(SWD_OFF_COUNT, 16'h0050, "load");
    foreach (bad[k]) wr(SWD_OFF_COUNT, bad[k]);
    rchk(SWD_OFF_COUNT, 16'h0050, "key");
    wr(SWD_OFF_COUNT, 16'h01AB);
    rchk(SWD_OFF_COUNT, 16'h01AB, "sign");
    $display("test done: key");
  endtask : t_key

  task t_tick;
    wr(SWD_OFF_COUNT, 16'h0050);
    run8();
    rchk(SWD_OFF_COUNT, 16'h004F, "tick");
    repeat (20) @(posedge core_clk);
    rchk(SWD_OFF_COUNT, 16'h004F, "halt");
    $display("test done: tick");
  endtask : t_tick

  task t_nmi;
    logic [7:0] n0;
    n0 = nmi_seen;
    wr(SWD_OFF_IRQ_MASK, 16'h0001);
    wr(SWD_OFF_COUNT, 16'h0001);
    wait_ev(1'b0);
    rchk(SWD_OFF_COUNT, 16'h0000, "zero");
    chk({15'h0000, irq}, 16'h0001, "irq on");
    rchk(SWD_OFF_IRQ_STAT, 16'h0001, "stat");
    wr(SWD_OFF_IRQ_STAT, 16'h0001);
    rchk(SWD_OFF_IRQ_STAT, 16'h0000, "w1c");
    chk({15'h0000, irq}, 16'h0000, "irq off");
    run8();
    rchk(SWD_OFF_COUNT, 16'h01FF, "wrap");
    chk({8'h00, nmi_seen}, {8'h00, n0 + 8'h01}, "one nmi");
    $display("test done: nmi");
  endtask : t_nmi

  task t_fire0;
    logic [7:0] n0;
    n0 = nmi_seen;
    wr(SWD_OFF_COUNT, 16'h01F2);
    wait_ev(1'b1);
    chk({8'h00, nmi_seen}, {8'h00, n0}, "no nmi");
    rchk(SWD_OFF_COUNT, 16'h00FF, "reload");
    chk({8'h00, long_seen}, 16'h0000, "pulse");
    $display("test done: fire0");
  endtask : t_fire0

  task t_mode1;
    logic [7:0] n0;
    n0 = nmi_seen;
    wr(SWD_OFF_CTRL, 16'h0001);
    wr(SWD_OFF_CTRL, 16'h0000);
    rchk(SWD_OFF_CTRL, 16'h0001, "sticky");
    wr(SWD_OFF_FREEZE, 16'h0001);
    rchk(SWD_OFF_FREEZE, 16'h0000, "no frz");
    wr(SWD_OFF_IRQ_STAT, 16'h0002);
    wr(SWD_OFF_IRQ_MASK, 16'h0002);
    rchk(SWD_OFF_IRQ_STAT, 16'h0000, "pre clr");
    chk({15'h0000, irq}, 16'h0000, "irq idle");
    wr(SWD_OFF_COUNT, 16'h0001);
    wait_ev(1'b1);
    chk({8'h00, nmi_seen}, {8'h00, n0}, "no nmi");
    rchk(SWD_OFF_COUNT, 16'h00FF, "reload");
    rchk(SWD_OFF_CTRL, 16'h0000, "mode clr");
    chk({15'h0000, irq}, 16'h0001, "irq rst");
    wr(SWD_OFF_IRQ_STAT, 16'h0002);
    rchk(SWD_OFF_IRQ_STAT, 16'h0000, "w1c");
    chk({15'h0000, irq}, 16'h0000, "irq off");
    $display("test done: mode1");
  endtask : t_mode1

  task t_freeze;
    wr(SWD_OFF_FREEZE, 16'h0001);
    rchk(SWD_OFF_FREEZE, 16'h0001, "frz");
    wr(SWD_OFF_COUNT, 16'h0050);
    run8();
    rchk(SWD_OFF_COUNT, 16'h0050, "held");
    wr(SWD_OFF_UNFREEZE, 16'h0001);
    run8();
    rchk(SWD_OFF_COUNT, 16'h004F, "resume");
    $display("test done: freeze");
  endtask : t_freeze

  task t_swrst;
    wr(SWD_OFF_CTRL, 16'h0001);
    @(posedge core_clk);
    sw_reset_req <= 1'b1;
    @(posedge core_clk);
    sw_reset_req <= 1'b0;
    rchk(SWD_OFF_CTRL, 16'h0000, "sw mode");
    rchk(SWD_OFF_COUNT, 16'h00FF, "sw count");
    $display("test done: swrst");
  endtask : t_swrst

  task tally_and_finish;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_key();
    t_tick();
    t_nmi();
    t_fire0();
    t_mode1();
    t_freeze();
    t_swrst();
    tally_and_finish();
  end
endmodule : test_system_watchdog_timer
